// ===== tpm_pkg.sv
// constants and types shared by the three-phase pwm core
// Notes on behaviour
// [RL1] port field gates upper and lower phase pins
// [RL2] tool break with high-z setting floats all
// [RL3] synthesis disabled means every pin high-z
// [RL4] emergency event uses emergency mode gating
// [RL5] source bit picks bus or engine values
// [RL6] compare, trigger, output shadows load at update
// [RL7] sixteen-bit counter, one count per clock
// [RL8] mode zero sawtooth, mode one triangle
// [RL9] extension bit slows counting four times
// [RL10] period shadow loads per period or half
// [RL11] phase output set by compare versus counter
// [RL12] shadows transfer at period match or half
// [RL13] independent mode uses own compare per phase
// [RL14] common mode drives all from phase a
// [RL15] interrupt every half, one, two, four periods
// [RL16] duty bit zero shares phase a compare
// [RL17] interval field encodes half, one, two, four
// [RL18] timing bit picks count one or period
// [RL19] sawtooth wraps, triangle reverses at both ends
// [RL20] undefined bits read zero, ignore writes
`default_nettype none
package tpm_pkg;
  localparam logic [7:0] OFS_ENABLE      = 8'h00;
  localparam logic [7:0] OFS_PORT        = 8'h04;
  localparam logic [7:0] OFS_CTRL        = 8'h08;
  localparam logic [7:0] OFS_CNT_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_COUNTER     = 8'h10;
  localparam logic [7:0] OFS_PERIOD      = 8'h14;
  localparam logic [7:0] OFS_CMP_A       = 8'h18;
  localparam logic [7:0] OFS_CMP_B       = 8'h1c;
  localparam logic [7:0] OFS_CMP_C       = 8'h20;
  localparam logic [7:0] OFS_SRC_SEL     = 8'h24;
  localparam logic [7:0] OFS_OUT_CTRL    = 8'h28;
  localparam logic [7:0] OFS_EMG_CTRL    = 8'h34;
  localparam logic [7:0] OFS_TRG0        = 8'h48;
  localparam logic [7:0] OFS_TRG1        = 8'h4c;

  localparam int CTRL_MODE_BIT   = 0;
  localparam int CTRL_INTPRD_LSB = 1;
  localparam int CTRL_IRQ_TIMING_BIT_BIT   = 3;
  localparam int CTRL_DUTY_BIT   = 4;
  localparam int CTRL_EXT_BIT    = 6;
  localparam logic [6:0] CTRL_MASK = 7'h5f;
  localparam int EMG_EN_BIT      = 0;
  localparam int EMG_MODE_LSB    = 1;
  localparam int EMG_CLR_BIT     = 3;
  localparam int EMG_FLAG_BIT    = 8;

  localparam logic [1:0] INTPRD_HALF = 2'h0;
  localparam logic [1:0] INTPRD_TWO  = 2'h2;
  localparam logic [1:0] INTPRD_FOUR = 2'h3;
  localparam logic [1:0] PORT_HIZ    = 2'h0;
  localparam logic [15:0] CNT_ONE    = 16'h0001;

  // count resolution in picoseconds
  localparam int RES_NORMAL_PS = 12500;
  localparam int RES_EXT_PS    = 50000;
  localparam int EXT_DIV       = RES_EXT_PS / RES_NORMAL_PS;
  localparam logic [1:0] EXT_LAST = 2'(EXT_DIV - 1);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [2:0][15:0] cmp;
    logic [15:0]      trg0;
    logic [15:0]      trg1;
    logic [5:0]       outctl;
  } tpm_buf_t;

  typedef struct packed {
    logic [2:0] upper_o;
    logic [2:0] upper_oe;
    logic [2:0] lower_o;
    logic [2:0] lower_oe;
  } tpm_pins_t;
endpackage : tpm_pkg
`default_nettype wire

// ===== tpm_carrier.sv
// carrier counter: sawtooth or triangle with optional slow count
`default_nettype none
module tpm_carrier
  import tpm_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic             tri_mode,
  input  wire logic             ext,
  input  wire logic [CNT_W-1:0] period,
  output logic      [CNT_W-1:0] cnt,
  output logic                  down,
  output logic                  step
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             down;
    logic [1:0]       pre;
  } tpm_car_state_t;

  tpm_car_state_t q;
  tpm_car_state_t next_q;

  // one count per clock, or one per four clocks when extended
  assign step = run && (!ext || q.pre == EXT_LAST); // RL7 RL9

  always_comb
  begin
    next_q = q;
    if (!run)
    begin
      next_q = '0;
    end
    else
    begin
      next_q.pre = ext ? 2'(q.pre + 2'h1) : 2'h0; // RL9
      if (step)
      begin
        if (!tri_mode)
        begin
          next_q.down = 1'b0;
          next_q.cnt  = (q.cnt >= period) ? '0 : CNT_W'(q.cnt + 1'b1); // RL8 RL19
        end
        else if (period == '0)
        begin
          next_q.cnt  = '0;
          next_q.down = 1'b0;
        end
        else if (!q.down)
        begin
          if (q.cnt >= period)
          begin
            next_q.down = 1'b1;
            next_q.cnt  = CNT_W'(q.cnt - 1'b1); // RL19
          end
          else
          begin
            next_q.cnt = CNT_W'(q.cnt + 1'b1);
          end
        end
        else if (q.cnt == '0)
        begin
          next_q.down = 1'b0;
          next_q.cnt  = CNT_W'(1); // RL19
        end
        else
        begin
          next_q.cnt = CNT_W'(q.cnt - 1'b1);
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= next_q;
  end

  assign cnt  = q.cnt;
  assign down = q.down;
endmodule : tpm_carrier
`default_nettype wire

// ===== tpm_compare.sv
// per-phase duty compare and trigger match
`default_nettype none
module tpm_compare
  import tpm_pkg::*;
(
  input  wire logic     step,
  input  wire logic     own_duty,
  input  wire logic [15:0] cnt,
  input  wire tpm_buf_t act,
  output logic [2:0]    wave,
  output logic [1:0]    trg_hit
);
  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_phase
      logic [15:0] duty;
      assign duty    = own_duty ? act.cmp[i] : act.cmp[0]; // RL13 RL14 RL16
      assign wave[i] = duty > cnt; // RL11
    end
  endgenerate

  assign trg_hit[0] = step && (cnt == act.trg0);
  assign trg_hit[1] = step && (cnt == act.trg1);
endmodule : tpm_compare
`default_nettype wire

// ===== tpm_core.sv
// three-phase pwm core with axi4-lite register slave
`default_nettype none
module tpm_core
  import tpm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  input  wire tpm_buf_t   ve_buf,
  input  wire logic       tool_break,
  input  wire logic       emg_in,
  output tpm_pins_t       pins,
  output logic            pwm_irq,
  output logic [1:0]      trg_pulse
);
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        arready;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        enable;
    logic [1:0]  portmd;
    logic [6:0]  ctrl;
    logic        src_sel;
    logic        emg_en;
    logic [1:0]  emg_mode;
    logic        emg_flag;
    logic [15:0] prd_wr;
    logic [15:0] prd_act;
    tpm_buf_t    buf_wr;
    tpm_buf_t    buf_act;
    logic [1:0]  irq_cnt;
    logic        irq;
    logic [1:0]  trg;
    tpm_pins_t   pins;
  } tpm_top_state_t;

  tpm_top_state_t q;
  tpm_top_state_t next_q;

  logic [15:0] cnt;
  logic        down;
  logic        step;
  logic [2:0]  wave;
  logic [1:0]  trg_hit;

  logic       tri_mode;
  logic       ext;
  logic       own_duty;
  logic       irq_timing_bit;
  logic [1:0] intprd;

  assign tri_mode = q.ctrl[CTRL_MODE_BIT];
  assign ext      = q.ctrl[CTRL_EXT_BIT];
  assign own_duty = q.ctrl[CTRL_DUTY_BIT];
  assign irq_timing_bit     = q.ctrl[CTRL_IRQ_TIMING_BIT_BIT];
  assign intprd   = q.ctrl[CTRL_INTPRD_LSB +: 2];

  tpm_carrier #(
    .CNT_W (16)
  ) u_carrier (
    .clk      (clk),
    .rst      (rst),
    .run      (q.enable),
    .tri_mode (tri_mode),
    .ext      (ext),
    .period   (q.prd_act),
    .cnt      (cnt),
    .down     (down),
    .step     (step)
  );

  tpm_compare u_compare (
    .step     (step),
    .own_duty (own_duty),
    .cnt      (cnt),
    .act      (q.buf_act),
    .wave     (wave),
    .trg_hit  (trg_hit)
  );

  // register read view; bit 32 flags a mapped offset
  function automatic logic [32:0] reg_value(
    input tpm_top_state_t st,
    input logic [7:0]     a,
    input logic [15:0]    c,
    input logic           dn
  );
    logic [32:0] v;
    v = {1'b1, 32'h0};
    unique case (a)
      OFS_ENABLE:     v[0]    = st.enable;
      OFS_PORT:       v[1:0]  = st.portmd;
      OFS_CTRL:       v[6:0]  = st.ctrl;
      OFS_CNT_STATUS: v[0]    = dn;
      OFS_COUNTER:    v[15:0] = c;
      OFS_PERIOD:     v[15:0] = st.prd_wr;
      OFS_CMP_A:      v[15:0] = st.buf_wr.cmp[0];
      OFS_CMP_B:      v[15:0] = st.buf_wr.cmp[1];
      OFS_CMP_C:      v[15:0] = st.buf_wr.cmp[2];
      OFS_SRC_SEL:    v[0]    = st.src_sel;
      OFS_OUT_CTRL:   v[5:0]  = st.buf_wr.outctl;
      OFS_EMG_CTRL:
      begin
        v[EMG_EN_BIT]            = st.emg_en;
        v[EMG_MODE_LSB +: 2]     = st.emg_mode;
        v[EMG_FLAG_BIT]          = st.emg_flag;
      end
      OFS_TRG0:       v[15:0] = st.buf_wr.trg0;
      OFS_TRG1:       v[15:0] = st.buf_wr.trg1;
      default:        v       = '0;
    endcase
    return v;
  endfunction : reg_value

  always_comb
  begin
    logic [32:0] rv;
    logic [31:0] wd;
    logic        emg_clr;
    logic        at_top;
    logic        at_one;
    logic        half;
    logic        upd;
    logic        per_evt;
    logic [1:0]  irq_last;
    logic [1:0]  gate;
    logic        all_hiz;
    next_q  = q;
    rv      = '0;
    wd      = '0;
    emg_clr = 1'b0;
    at_top   = 1'b0;
    at_one   = 1'b0;
    half     = 1'b0;
    upd      = 1'b0;
    per_evt  = 1'b0;
    irq_last = 2'h0;
    gate     = 2'h0;
    all_hiz  = 1'b0;
    next_q.irq = 1'b0;

    // bus response retirement
    if (q.bvalid && s_axi_bready)
      next_q.bvalid = 1'b0;
    if (q.rvalid && s_axi_rready)
      next_q.rvalid = 1'b0;

    if (s_axi_awvalid && q.awready)
    begin
      next_q.aw_held = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      next_q.w_held = 1'b1;
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
    end

    if (q.aw_held && q.w_held && !q.bvalid)
    begin
      rv = reg_value(q, q.aw_addr, cnt, down);
      for (int b = 0; b < 4; b++)
        wd[8*b +: 8] = q.w_strb[b] ? q.w_data[8*b +: 8] : rv[8*b +: 8];
      next_q.aw_held = 1'b0;
      next_q.w_held  = 1'b0;
      next_q.bvalid  = 1'b1;
      next_q.bresp   = rv[32] ? RESP_OKAY : RESP_DECERR;
      unique case (q.aw_addr)
        OFS_ENABLE:   next_q.enable         = wd[0];
        OFS_PORT:     next_q.portmd         = wd[1:0];
        OFS_CTRL:     next_q.ctrl           = wd[6:0] & CTRL_MASK; // RL20
        OFS_PERIOD:   next_q.prd_wr         = wd[15:0];
        OFS_CMP_A:    next_q.buf_wr.cmp[0]  = wd[15:0];
        OFS_CMP_B:    next_q.buf_wr.cmp[1]  = wd[15:0];
        OFS_CMP_C:    next_q.buf_wr.cmp[2]  = wd[15:0];
        OFS_SRC_SEL:  next_q.src_sel        = wd[0];
        OFS_OUT_CTRL: next_q.buf_wr.outctl  = wd[5:0];
        OFS_EMG_CTRL:
        begin
          next_q.emg_en   = wd[EMG_EN_BIT];
          next_q.emg_mode = wd[EMG_MODE_LSB +: 2];
          emg_clr         = wd[EMG_CLR_BIT];
        end
        OFS_TRG0:     next_q.buf_wr.trg0    = wd[15:0];
        OFS_TRG1:     next_q.buf_wr.trg1    = wd[15:0];
        default:      next_q.bresp          = rv[32] ? RESP_OKAY : RESP_DECERR;
      endcase
    end

    if (s_axi_arvalid && q.arready)
    begin
      rv            = reg_value(q, s_axi_araddr, cnt, down);
      next_q.rvalid = 1'b1;
      next_q.rdata  = rv[31:0]; // RL20
      next_q.rresp  = rv[32] ? RESP_OKAY : RESP_DECERR;
    end

    next_q.awready = !next_q.aw_held && !next_q.bvalid;
    next_q.wready  = !next_q.w_held && !next_q.bvalid;
    next_q.arready = !next_q.rvalid;

    // emergency latch, a new event beats a clear
    next_q.emg_flag = (q.emg_flag && !emg_clr) || (q.emg_en && emg_in);

    // carrier events
    at_top = step && (cnt == q.prd_act);
    at_one = step && tri_mode && down && (cnt == CNT_ONE);
    half   = tri_mode && (intprd == INTPRD_HALF);
    upd    = at_top || (half && at_one) || !q.enable; // RL10 RL12

    if (upd)
    begin
      next_q.prd_act = q.prd_wr; // RL10
      next_q.buf_act = q.src_sel ? ve_buf : q.buf_wr; // RL5 RL6 RL12
    end

    // interrupt pacing
    per_evt  = (!tri_mode || irq_timing_bit) ? at_top : at_one; // RL18
    irq_last = (intprd == INTPRD_FOUR) ? 2'h3 :
               (intprd == INTPRD_TWO) ? 2'h1 : 2'h0; // RL17
    if (!q.enable)
    begin
      next_q.irq_cnt = 2'h0;
    end
    else if (half)
    begin
      next_q.irq = at_top || at_one; // RL15 RL17
    end
    else if (per_evt)
    begin
      // at or past the last count wraps at once when the interval shrinks
      next_q.irq     = (q.irq_cnt >= irq_last); // RL15
      next_q.irq_cnt = (q.irq_cnt >= irq_last) ? 2'h0 : 2'(q.irq_cnt + 2'h1);
    end

    next_q.trg = q.enable ? trg_hit : 2'h0;

    // pin gating
    gate    = q.emg_flag ? q.emg_mode : q.portmd; // RL1 RL4
    all_hiz = !q.enable || (tool_break && q.portmd == PORT_HIZ); // RL2 RL3
    next_q.pins.upper_oe = {3{!all_hiz && gate[1]}}; // RL1
    next_q.pins.lower_oe = {3{!all_hiz && gate[0]}}; // RL1
    next_q.pins.upper_o  = wave & ~q.buf_act.outctl[2:0] & next_q.pins.upper_oe;
    next_q.pins.lower_o  = ~wave & ~q.buf_act.outctl[5:3] & next_q.pins.lower_oe;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= next_q;
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_arready = q.arready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign pins          = q.pins;
  assign pwm_irq       = q.irq;
  assign trg_pulse     = q.trg;
endmodule : tpm_core
`default_nettype wire

// ===== tpm_core_assertions.sv
// port assertions for the three-phase pwm core
`default_nettype none
module tpm_core_chk
  import tpm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire tpm_pins_t   pins,
  input wire logic        pwm_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  read_answer_a : assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  read_hold_a : assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  write_hold_a : assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_block_a : assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read answer");
  write_block_a : assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  write_reopen_a : assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##0 s_axi_awready)
    else $error("write channel not reopened");
  float_low_a : assert property (((pins.upper_o & ~pins.upper_oe) | (pins.lower_o & ~pins.lower_oe)) == 3'h0)
    else $error("undriven pin shows high");
  no_shoot_a : assert property ((pins.upper_o & pins.lower_o) == 3'h0)
    else $error("upper and lower both high");
  irq_pulse_a : assert property (pwm_irq |=> !pwm_irq)
    else $error("interrupt wider than one cycle");
  cover property (pwm_irq);
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_DECERR);
  cover property (pins.upper_oe == 3'h7 && pins.lower_oe == 3'h7);
endmodule : tpm_core_chk
bind tpm_core tpm_core_chk tpm_core_chk_i (.clk(clk), .rst(rst), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pins(pins), .pwm_irq(pwm_irq));
`default_nettype wire

// ===== tpm_gate_drv.sv
// gate driver model: levels past the pull-down resistors
`default_nettype none
module tpm_gate_drv
  import tpm_pkg::*;
(
  input  wire tpm_pins_t pins,
  output logic [2:0]     gate_hi,
  output logic [2:0]     gate_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  // a floating gate input is pulled low
  assign gate_hi = pins.upper_o & pins.upper_oe;
  assign gate_lo = pins.lower_o & pins.lower_oe;
endmodule : tpm_gate_drv
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the three-phase pwm core
`default_nettype none
module tb_top
  import tpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tool_break = 1'b0, emg_in = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, trg_pulse, resp;
  logic [31:0] s_axi_rdata, rd;
  logic [2:0]  gate_hi, gate_lo;
  tpm_pins_t   pins;
  tpm_buf_t    ve_buf = {16'h0001, 16'h0002, 16'h0005, 16'h0000, 16'h0000, 6'h00};
  int          bad_count = 0, n_checks = 0, cyc = 0, hi_a, hi_b, irqs, lo_a, trgs;

  tpm_core tpm_core_i (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ve_buf(ve_buf), .tool_break(tool_break), .emg_in(emg_in),
    .pins(pins), .pwm_irq(pwm_irq), .trg_pulse(trg_pulse));
  tpm_gate_drv tpm_gate_drv_i (.pins(pins), .gate_hi(gate_hi), .gate_lo(gate_lo));

  initial forever #20 clk = ~clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (!ta && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (!tw && s_axi_wready) s_axi_wvalid <= 1'b0;
      ta |= s_axi_awready;
      tw |= s_axi_wready;
    end
    while (!(ta && tw));
    do @(posedge clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk($sformatf("register %h", a), rd, exp);
  endtask : rchk

  // counts upper gate highs on a and b, lower gate highs on a, interrupts and triggers over a window
  task automatic measure(input int win);
    hi_a = 0;
    hi_b = 0;
    irqs = 0;
    lo_a = 0;
    trgs = 0;
    repeat (win)
    begin
      @(negedge clk);
      hi_a += gate_hi[0];
      hi_b += gate_hi[1];
      irqs += pwm_irq;
      lo_a += gate_lo[0];
      trgs += trg_pulse[0] + trg_pulse[1];
    end
  endtask : measure

  task automatic oe_chk(input logic [2:0] up, input logic [2:0] lo);
    repeat (5) @(posedge clk);
    chk("upper enables", {29'h0, pins.upper_oe}, {29'h0, up});
    chk("lower enables", {29'h0, pins.lower_oe}, {29'h0, lo});
  endtask : oe_chk

  initial
  begin
    // control, window, irqs, high a, high b; period 9, compares 3 and 6
    int tab[8][5];
    tab = '{'{16, 10, 1, 3, 6}, '{0, 10, 1, 3, 3}, '{20, 20, 1, 6, 12}, '{22, 40, 1, 12, 24},
      '{80, 40, 1, 12, 24}, '{17, 18, 2, 5, 11}, '{27, 18, 1, 5, 11}, '{19, 18, 1, 5, 11}};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(OFS_ENABLE, 32'h0);
    rchk(OFS_PORT, 32'h0);
    rchk(OFS_SRC_SEL, 32'h0);
    wr(OFS_PORT, 32'hffffffff);
    rchk(OFS_PORT, 32'h3);
    wr(OFS_CTRL, 32'hffffffff);
    rchk(OFS_CTRL, {25'h0, CTRL_MASK});
    wr(OFS_SRC_SEL, 32'hffffffff);
    rchk(OFS_SRC_SEL, 32'h1);
    wr(OFS_SRC_SEL, 32'h0);
    rd_reg(8'h7c);
    chk("unmapped read", {rd[31:2], resp}, {30'h0, RESP_DECERR});
    wr(8'h78, 32'h1);
    chk("unmapped write", {30'h0, resp}, {30'h0, RESP_DECERR});
    wr(OFS_PERIOD, 32'h9);
    wr(OFS_CMP_A, 32'h3);
    wr(OFS_CMP_B, 32'h6);
    wr(OFS_CMP_C, 32'h0);
    wr(OFS_TRG1, 32'h4);
    wr(OFS_CTRL, 32'h10);
    oe_chk(3'h0, 3'h0);
    wr(OFS_ENABLE, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_CTRL, 32'(tab[i][0]));
      repeat (80) @(posedge clk);
      measure(tab[i][1]);
      chk("interrupts", 32'(irqs), 32'(tab[i][2]));
      chk("duty a", 32'(hi_a), 32'(tab[i][3]));
      chk("duty b", 32'(hi_b), 32'(tab[i][4]));
      chk("low a", 32'(lo_a), 32'(tab[i][1] - tab[i][3]));
      if (i == 5) chk("triggers", 32'(trgs), 32'h3);
    end
    // force-low mask on upper and lower phase a
    wr(OFS_OUT_CTRL, 32'h9);
    repeat (80) @(posedge clk);
    measure(18);
    chk("forced a", 32'(hi_a), 32'h0);
    chk("forced low a", 32'(lo_a), 32'h0);
    chk("free b", 32'(hi_b), 32'd11);
    wr(OFS_OUT_CTRL, 32'h0);
    wr(OFS_SRC_SEL, 32'h1);
    wr(OFS_CTRL, 32'h10);
    repeat (80) @(posedge clk);
    measure(10);
    chk("engine duty a", 32'(hi_a), 32'h5);
    chk("engine duty b", 32'(hi_b), 32'h2);
    wr(OFS_SRC_SEL, 32'h0);
    for (int t = 0; t < 2; t++)
      for (int p = 0; p < 4; p++)
      begin
        tool_break <= t[0];
        wr(OFS_PORT, 32'(p));
        if (t == 1 && p == 0) oe_chk(3'h0, 3'h0);
        else oe_chk({3{p[1]}}, {3{p[0]}});
      end
    tool_break <= 1'b0;
    wr(OFS_EMG_CTRL, 32'h1);
    emg_in <= 1'b1;
    oe_chk(3'h0, 3'h0);
    rchk(OFS_EMG_CTRL, 32'h101);
    emg_in <= 1'b0;
    wr(OFS_EMG_CTRL, 32'h9);
    oe_chk(3'h7, 3'h7);
    // emergency mode drives both sides while the port field floats them
    wr(OFS_EMG_CTRL, 32'h7);
    wr(OFS_PORT, 32'h0);
    emg_in <= 1'b1;
    oe_chk(3'h7, 3'h7);
    tool_break <= 1'b1;
    oe_chk(3'h0, 3'h0);
    tool_break <= 1'b0;
    emg_in <= 1'b0;
    wr(OFS_EMG_CTRL, 32'h8);
    wr(OFS_PORT, 32'h3);
    oe_chk(3'h7, 3'h7);
    wr(OFS_ENABLE, 32'h0);
    oe_chk(3'h0, 3'h0);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
